/* File: hdl/pkt_regs_pkg.sv */
// constants and types shared by the packet generator register bank
package pkt_regs_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [11:0] IDX_GEN_PATTERN_LOW  = 12'h625;
  localparam logic [11:0] IDX_GEN_PATTERN_MID  = 12'h626;
  localparam logic [11:0] IDX_GEN_PATTERN_HIGH = 12'h627;
  localparam logic [11:0] IDX_DEST_MATCH_LOW   = 12'h628;
  localparam logic [11:0] IDX_DEST_MATCH_MID   = 12'h629;
  localparam logic [11:0] IDX_DEST_MATCH_HIGH  = 12'h62a;
  localparam logic [11:0] IDX_CRC_ERROR_FLAGS  = 12'h638;
  localparam logic [11:0] IDX_TX_COUNT_LOW     = 12'h639;
  localparam logic [11:0] IDX_TX_COUNT_HIGH    = 12'h63a;
  localparam logic [11:0] IDX_TX_ERR_COUNT     = 12'h63b;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          POS_RX_BAD_CRC = 1;
  localparam int          POS_TX_BAD_CRC = 0;
  localparam logic [15:0] RESET_WORD     = 16'h0000;
  localparam logic [31:0] RESET_COUNT    = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // ****************************************************************
  // bus encodings
  // ****************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // one completed packet from the generator or checker datapath
  typedef struct packed {
    logic done;    // one-cycle pulse at packet end
    logic crc_err; // packet carried a bad crc
  } pkt_event_type;

  // destination address presented by the checker
  typedef struct packed {
    logic        valid;
    logic [47:0] addr;
  } dest_addr_type;

  // read sequence tracker for clearing the transmit statistics
  typedef enum logic [2:0] {
    SEQ_IDLE     = 3'h1,
    SEQ_GOT_LOW  = 3'h2,
    SEQ_GOT_HIGH = 3'h4
  } clear_seq_type;

endpackage : pkt_regs_pkg

/* File: hdl/pkt_gen_match_crc_counters.sv */
// register bank for the packet generator pattern, address match and tx statistics
// Summary of operation
// - pattern bits 47:32 word, read/write, resets zero
// - compare received destination address with match value
// - match value in three words, each resets zero
// - status bit 1 flags receive crc error
// - status bit 0 flags transmit crc error
// - lower 16 transmit count bits readable, reset zero
// - reading three tx statistics words in order clears
// - upper 16 transmit count bits at next word
// - third word counts transmitted packets with crc error
// - pattern bits 15:0 and 31:16 in own words
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps

module pkt_gen_match_crc_counters (
  input  wire logic                        CLOCK,
  input  wire logic                        RST,
  // ahb-lite slave
  input  wire logic                        HSEL,
  input  wire logic [31:0]                 HADDR,
  input  wire logic [1:0]                  HTRANS,
  input  wire logic                        HWRITE,
  input  wire logic [2:0]                  HSIZE,
  input  wire logic [31:0]                 HWDATA,
  input  wire logic                        HREADY,
  output logic      [31:0]                 HRDATA,
  output logic                             HREADYOUT,
  output logic                             HRESP,
  // packet datapath side
  input  wire pkt_regs_pkg::pkt_event_type TX_PKT,
  input  wire pkt_regs_pkg::pkt_event_type RX_PKT,
  input  wire pkt_regs_pkg::dest_addr_type RX_DEST,
  output logic      [47:0]                 GEN_PATTERN,
  output logic                             DEST_MATCH
);

  // ****************************************************************
  // bus address phase
  // ****************************************************************
  logic        addr_phase;
  logic        wr_phase_q;
  logic [11:0] wr_idx_q;
  logic [11:0] rd_idx;
  logic        word_aligned;

  // only whole-word, aligned transfers write or read the registers; any read steps the clear sequence
  assign word_aligned = (HADDR[1:0] == 2'h0) && (HSIZE == 3'h2);
  assign addr_phase   = HSEL && HREADY && (HTRANS == pkt_regs_pkg::HTRANS_NONSEQ);
  assign rd_idx       = HADDR[13:2];

  // remember a write address until its data phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_phase_q <= 1'b0;
      wr_idx_q   <= 12'h000;
    end else begin
      wr_phase_q <= addr_phase && HWRITE && word_aligned && (HADDR[31:14] == 18'h00000);
      wr_idx_q   <= rd_idx;
    end
  end

  // never stalls, never errors
  assign HREADYOUT = 1'b1;
  assign HRESP     = pkt_regs_pkg::HRESP_OKAY;

  // ****************************************************************
  // pattern and match words
  // ****************************************************************
  logic [15:0] pat_low_q;
  logic [15:0] pat_mid_q;
  logic [15:0] pat_high_q;
  logic [15:0] match_low_q;
  logic [15:0] match_mid_q;
  logic [15:0] match_high_q;

  // software writes land at the end of the data phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pat_low_q    <= pkt_regs_pkg::RESET_WORD;
      pat_mid_q    <= pkt_regs_pkg::RESET_WORD;
      pat_high_q   <= pkt_regs_pkg::RESET_WORD;
      match_low_q  <= pkt_regs_pkg::RESET_WORD;
      match_mid_q  <= pkt_regs_pkg::RESET_WORD;
      match_high_q <= pkt_regs_pkg::RESET_WORD;
    end else if (wr_phase_q) begin
      unique case (wr_idx_q)
        pkt_regs_pkg::IDX_GEN_PATTERN_LOW:  pat_low_q    <= HWDATA[15:0];
        pkt_regs_pkg::IDX_GEN_PATTERN_MID:  pat_mid_q    <= HWDATA[15:0];
        pkt_regs_pkg::IDX_GEN_PATTERN_HIGH: pat_high_q   <= HWDATA[15:0];
        pkt_regs_pkg::IDX_DEST_MATCH_LOW:   match_low_q  <= HWDATA[15:0];
        pkt_regs_pkg::IDX_DEST_MATCH_MID:   match_mid_q  <= HWDATA[15:0];
        pkt_regs_pkg::IDX_DEST_MATCH_HIGH:  match_high_q <= HWDATA[15:0];
        default: ;                            // read-only or unmapped: ignored
      endcase
    end
  end

  // pattern goes to the generator from flops
  assign GEN_PATTERN = {pat_high_q, pat_mid_q, pat_low_q};

  // ****************************************************************
  // destination address match
  // ****************************************************************
  logic dest_match_q;

  // registered one-cycle answer for each presented address
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dest_match_q <= 1'b0;
    end else begin
      dest_match_q <= RX_DEST.valid &&
                      (RX_DEST.addr == {match_high_q, match_mid_q, match_low_q});
    end
  end

  assign DEST_MATCH = dest_match_q;

  // ****************************************************************
  // crc error flags
  // ****************************************************************
  logic rx_bad_crc_q;
  logic tx_bad_crc_q;

  // each flag tracks the last finished packet in its direction
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_bad_crc_q <= 1'b0;
      tx_bad_crc_q <= 1'b0;
    end else begin
      if (RX_PKT.done) begin
        rx_bad_crc_q <= RX_PKT.crc_err;
      end
      if (TX_PKT.done) begin
        tx_bad_crc_q <= TX_PKT.crc_err;
      end
    end
  end

  // ****************************************************************
  // clear-on-read sequence
  // ****************************************************************
  pkt_regs_pkg::clear_seq_type seq_q;
  logic                        rd_accept;
  logic                        clear_stats;

  assign rd_accept   = addr_phase && !HWRITE;
  // the third read of the sequence clears after its value is captured
  assign clear_stats = rd_accept && (seq_q == pkt_regs_pkg::SEQ_GOT_HIGH) &&
                       (rd_idx == pkt_regs_pkg::IDX_TX_ERR_COUNT);

  // any other transfer in between restarts the sequence
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      seq_q <= pkt_regs_pkg::SEQ_IDLE;
    end else if (addr_phase) begin
      if (rd_accept && rd_idx == pkt_regs_pkg::IDX_TX_COUNT_LOW) begin
        seq_q <= pkt_regs_pkg::SEQ_GOT_LOW;
      end else if (rd_accept && seq_q == pkt_regs_pkg::SEQ_GOT_LOW &&
                   rd_idx == pkt_regs_pkg::IDX_TX_COUNT_HIGH) begin
        seq_q <= pkt_regs_pkg::SEQ_GOT_HIGH;
      end else begin
        seq_q <= pkt_regs_pkg::SEQ_IDLE;
      end
    end
  end

  // ****************************************************************
  // transmit statistics counters
  // ****************************************************************
  logic [31:0] tx_count_q;
  logic [15:0] tx_err_count_q;

  // a packet finishing on the clearing cycle is counted, not lost
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_count_q     <= pkt_regs_pkg::RESET_COUNT;
      tx_err_count_q <= pkt_regs_pkg::RESET_WORD;
    end else begin
      if (clear_stats) begin
        tx_count_q <= {31'h0000_0000, TX_PKT.done};
      end else if (TX_PKT.done) begin
        tx_count_q <= tx_count_q + 32'h0000_0001;
      end
      if (clear_stats) begin
        tx_err_count_q <= {15'h0000, TX_PKT.done && TX_PKT.crc_err};
      end else if (TX_PKT.done && TX_PKT.crc_err) begin
        tx_err_count_q <= tx_err_count_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [15:0] rd_word;
  logic [15:0] fwd_word;
  logic [31:0] hrdata_q;

  // read mux, zero for unmapped words and reserved bits
  always_comb begin
    rd_word = 16'h0000;
    unique case (rd_idx)
      pkt_regs_pkg::IDX_GEN_PATTERN_LOW:  rd_word = pat_low_q;
      pkt_regs_pkg::IDX_GEN_PATTERN_MID:  rd_word = pat_mid_q;
      pkt_regs_pkg::IDX_GEN_PATTERN_HIGH: rd_word = pat_high_q;
      pkt_regs_pkg::IDX_DEST_MATCH_LOW:   rd_word = match_low_q;
      pkt_regs_pkg::IDX_DEST_MATCH_MID:   rd_word = match_mid_q;
      pkt_regs_pkg::IDX_DEST_MATCH_HIGH:  rd_word = match_high_q;
      pkt_regs_pkg::IDX_CRC_ERROR_FLAGS: begin
        rd_word[pkt_regs_pkg::POS_RX_BAD_CRC] = rx_bad_crc_q;
        rd_word[pkt_regs_pkg::POS_TX_BAD_CRC] = tx_bad_crc_q;
      end
      pkt_regs_pkg::IDX_TX_COUNT_LOW:     rd_word = tx_count_q[15:0];
      pkt_regs_pkg::IDX_TX_COUNT_HIGH:    rd_word = tx_count_q[31:16];
      pkt_regs_pkg::IDX_TX_ERR_COUNT:     rd_word = tx_err_count_q;
      default: ;
    endcase
  end

  // a read right behind a write to the same word sees the new value
  assign fwd_word = (wr_phase_q && wr_idx_q == rd_idx) ? HWDATA[15:0] : rd_word;

  // capture at the address phase so the data phase needs no wait state
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      hrdata_q <= pkt_regs_pkg::READ_ZERO;
    end else if (rd_accept) begin
      if (word_aligned && HADDR[31:14] == 18'h00000) begin
        hrdata_q <= {16'h0000, fwd_word};
      end else begin
        hrdata_q <= pkt_regs_pkg::READ_ZERO;
      end
    end
  end

  assign HRDATA = hrdata_q;

endmodule : pkt_gen_match_crc_counters

/* File: bench/pkt_regs_chk.sv */
// assertion checker for the packet generator register bank
`timescale 1ns/100ps

module pkt_regs_chk (
  input wire logic                        CLOCK,
  input wire logic                        RST,
  input wire logic                        HSEL,
  input wire logic [31:0]                 HADDR,
  input wire logic [1:0]                  HTRANS,
  input wire logic                        HWRITE,
  input wire logic [2:0]                  HSIZE,
  input wire logic [31:0]                 HWDATA,
  input wire logic                        HREADY,
  input wire logic [31:0]                 HRDATA,
  input wire logic                        HREADYOUT,
  input wire logic                        HRESP,
  input wire pkt_regs_pkg::pkt_event_type TX_PKT,
  input wire pkt_regs_pkg::pkt_event_type RX_PKT,
  input wire pkt_regs_pkg::dest_addr_type RX_DEST,
  input wire logic [47:0]                 GEN_PATTERN,
  input wire logic                        DEST_MATCH
);
  // ****************************************************************
  // accepted word transfers and their properties
  // ****************************************************************
  logic        acc;
  logic        rd;
  logic        wr;
  logic [11:0] idx;
  // decode of an accepted address phase, word size only
  assign acc = HSEL && HREADY && HTRANS == 2'h2 && HSIZE == 3'h2 && HADDR[31:14] == 18'h0;
  assign rd  = acc && !HWRITE;
  assign wr  = acc && HWRITE;
  assign idx = HADDR[13:2];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  pat_high_a: assert property (wr && idx == 12'h627 |=> ##1
    {16'h0, GEN_PATTERN[47:32]} == ($past(HWDATA) & 32'hffff)) else $error("pattern high bad");
  pat_low_a: assert property (wr && idx == 12'h625 |=> ##1
    {16'h0, GEN_PATTERN[15:0]} == ($past(HWDATA) & 32'hffff)) else $error("pattern low bad");
  pat_hold_a: assert property (!$stable(GEN_PATTERN) |-> $past(wr, 2) || $past(RST))
    else $error("pattern changed without write");
  rst_zero_a: assert property ($fell(RST) |-> GEN_PATTERN == 48'h0 && !DEST_MATCH)
    else $error("outputs not zero after reset");
  rsv_zero_a: assert property (rd && idx == 12'h638 |=> HRDATA[31:2] == 30'h0)
    else $error("reserved status bits not zero");
  tx_flag_a: assert property (rd && idx == 12'h638 && $past(TX_PKT.done) && !TX_PKT.done
    && !$past(RST) |=> HRDATA[0] == $past(TX_PKT.crc_err, 2)) else $error("tx flag bad");
  rx_flag_a: assert property (rd && idx == 12'h638 && $past(RX_PKT.done) && !RX_PKT.done
    && !$past(RST) |=> HRDATA[1] == $past(RX_PKT.crc_err, 2)) else $error("rx flag bad");
  match_src_a: assert property (DEST_MATCH |-> $past(RX_DEST.valid))
    else $error("match without address");

  clr_seq_c: cover property (rd && idx == 12'h63b);
  match_c: cover property (DEST_MATCH);
  pat_wr_c: cover property (wr && idx == 12'h627);
endmodule : pkt_regs_chk

bind pkt_gen_match_crc_counters pkt_regs_chk u_chk (.*);

/* File: bench/pkt_gen_match_crc_counters_test.sv */
// self-checking testbench for the packet generator register bank
`timescale 1ns/100ps

module pkt_gen_match_crc_counters_test;
  // ****************************************************************
  // signals, bus tasks and test sequence
  // ****************************************************************
  logic                        clock, rst, hsel, hwrite, hready, hresp, dmatch;
  logic [1:0]                  htrans;
  logic [2:0]                  hsize;
  logic [31:0]                 haddr, hwdata, hrdata, d;
  logic [47:0]                 gpat;
  pkt_regs_pkg::pkt_event_type tx_pkt, rx_pkt;
  pkt_regs_pkg::dest_addr_type rx_dest;
  int                          error_cnt, cmp_count;
  logic [11:0] idx_l [11] = '{12'h625, 12'h626, 12'h627, 12'h628, 12'h629, 12'h62a,
                              12'h638, 12'h639, 12'h63a, 12'h63b, 12'h630};
  logic [15:0] wv [6] = '{16'h1234, 16'h5678, 16'h9abc, 16'h0ff1, 16'he00d, 16'h8001};
  logic        txe [3] = '{1'b1, 1'b0, 1'b1};
  logic [11:0] sq_i [9] = '{12'h63b, 12'h63a, 12'h639, 12'h63b, 12'h639, 12'h63a,
                            12'h63b, 12'h639, 12'h63b};
  logic [31:0] sq_e [9] = '{32'h2, 32'h0, 32'h3, 32'h2, 32'h3, 32'h0, 32'h2, 32'h0, 32'h0};

  // single bus slave, so hreadyout is the bus ready
  pkt_gen_match_crc_counters u_dut (
    .CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .TX_PKT(tx_pkt),
    .RX_PKT(rx_pkt), .RX_DEST(rx_dest), .GEN_PATTERN(gpat), .DEST_MATCH(dmatch)
  );

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // one single word transfer; waits are bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [11:0] i, input logic [15:0] wd,
                      output logic [31:0] rdat);
    int n;
    hsel <= 1'b1;
    htrans <= pkt_regs_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {18'h0, i, 2'h0};
    n = 0;
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 16);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 32);
    rdat = hrdata;
    if (hready !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask : xfer

  initial begin
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; tx_pkt = '0; rx_pkt = '0; rx_dest = '0;
    error_cnt = 0; cmp_count = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    // every word reads zero after reset, unmapped word too
    foreach (idx_l[i]) begin xfer(1'b0, idx_l[i], 16'h0, d); chk(d, 48'h0); end
    $display("test reset done");
    // pattern and match words written, read back; read-only write ignored
    foreach (wv[i]) xfer(1'b1, idx_l[i], wv[i], d);
    xfer(1'b1, 12'h639, 16'hffff, d);
    foreach (wv[i]) begin xfer(1'b0, idx_l[i], 16'h0, d); chk(d, wv[i]); end
    chk(gpat, {wv[2], wv[1], wv[0]});
    $display("test words done");
    // matching then differing destination address
    rx_dest <= {1'b1, wv[5], wv[4], wv[3]};
    @(posedge clock);
    rx_dest <= {1'b1, wv[5], wv[4], wv[3] ^ 16'h0100};
    @(negedge clock);
    chk(dmatch, 1'b1);
    @(posedge clock);
    rx_dest <= '0;
    @(negedge clock);
    chk(dmatch, 1'b0);
    chk(hresp, pkt_regs_pkg::HRESP_OKAY);
    @(posedge clock);
    $display("test match done");
    // three tx packets, rx errors opposite, so flags show only the last
    foreach (txe[i]) begin
      tx_pkt <= {1'b1, txe[i]};
      rx_pkt <= {1'b1, ~txe[i]};
      @(posedge clock);
    end
    tx_pkt <= '0;
    rx_pkt <= '0;
    xfer(1'b0, 12'h638, 16'h0, d);
    chk(d, 48'h1);
    // broken then complete ascending read sequence
    foreach (sq_i[i]) begin xfer(1'b0, sq_i[i], 16'h0, d); chk(d, sq_e[i]); end
    $display("test counters done");
    print_verdict();
  end
endmodule : pkt_gen_match_crc_counters_test
